// [src/memory_map_pkg.sv]
// Purpose: Shared constants and types for the program and data memory decoder.
// Assumes: One core clock; data offsets are seven bits, full data addresses nine.
// Notes:   Register indexes equal the data offsets inside the selected bank.

package memory_map_pkg;

	// ----------------------------------------------------------------
	// Program space
	// ----------------------------------------------------------------
	localparam int PC_W = 13;
	localparam int PROG_AW = 10;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam logic [4:0] PC_HIGH_LATCH_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Data space offsets within a bank
	// ----------------------------------------------------------------
	localparam logic [6:0] OFF_INDIRECT = 7'h00;
	localparam logic [6:0] OFF_PC_LOW = 7'h02;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_POINTER = 7'h04;
	localparam logic [6:0] OFF_PC_HIGH_LATCH = 7'h0A;
	localparam logic [6:0] SFR_TOP = 7'h1F;
	localparam logic [6:0] RAM_LO = 7'h40;
	localparam logic [6:0] RAM_HI = 7'h6F;
	localparam logic [6:0] COMMON_LO = 7'h70;
	localparam int RAM_DEPTH = 64;
	localparam int RAM_BANK0_WORDS = 48;

	// ----------------------------------------------------------------
	// Core status layout
	// ----------------------------------------------------------------
	localparam int STATUS_IRP = 7;
	localparam int STATUS_BANK_HI = 6;
	localparam int STATUS_BANK_LO = 5;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] STATUS_WMASK = 8'hE7;
	localparam logic [7:0] POINTER_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Bus
	// ----------------------------------------------------------------
	localparam int APB_AW = 12;

	typedef enum {region_none, region_sfr, region_ram} region_e;
	typedef enum {apb_idle, apb_busy, apb_done} apb_state_e;

	typedef struct packed {
		logic we;
		logic [6:0] off;
		logic [7:0] wdata;
		logic from_apb;
		logic blank;
	} data_req_s;

endpackage : memory_map_pkg

// [src/data_ram.sv]
// Purpose: Small single-port byte store for general purpose and common RAM.
// Assumes: Write and read share one address; read data appear one edge later.
// Notes:   Contents are not reset, as in the real array.

`timescale 1ns/1ns
`default_nettype none

module data_ram #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_q
);

	logic [7:0] mem [DEPTH];

	generate
		if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_param
			$error("data_ram: depth does not fit the address width");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// Write-first so a read in the same cycle as a write returns the new byte.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (we) begin
			rdata_q <= wdata;
		end else begin
			rdata_q <= mem[addr];
		end
	end

endmodule : data_ram

`default_nettype wire

// [src/memory_map_bank_decoder.sv]
// Purpose: Program counter with wrap into implemented program space, and the
//          banked data space decoder with core registers and data RAM.
// Assumes: Core and APB share pclk; core requests win over APB requests.
// Notes:   Every data access answers two edges after it is taken.
//
// Notes on behaviour
// (RQ1) The program counter is 13 bits wide, spanning 8K words of 14 bits.
// (RQ2) Only program addresses 0000h to 03FFh reach physical storage.
// (RQ3) Fetches above 03FFh use only the low ten address bits and so wrap.
// (RQ4) Every reset loads the program counter with 0000h.
// (RQ5) Taking an interrupt loads the program counter with 0004h.
// (RQ6) Four banks exist and offsets 00h to 1Fh of each decode to registers.
// (RQ7) Bank 0 offsets 40h to 6Fh reach general purpose RAM.
// (RQ8) Offsets 70h to 7Fh of every bank reach the same 16 common bytes.
// (RQ9) Reads of unimplemented data addresses return zero.
// (RQ10) Two bank select bits in the core status pick banks 0 to 3.
// (RQ11) All 64 RAM bytes are reachable directly and through the pointer.
// (RQ12) A direct address is the bank select bits followed by the offset.
// (RQ13) The indirect port redirects to the address held in the pointer.
//
// Decided for this implementation: the APB slave port.

`timescale 1ns/1ns
`default_nettype none

module memory_map_bank_decoder
	import memory_map_pkg::*;
#(
	parameter int PROG_W = PROG_AW,
	parameter int RAM_WORDS = RAM_DEPTH,
	parameter int BUS_AW = APB_AW
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [BUS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pc_step,
	input wire logic pc_jump,
	input wire logic [PC_W-1:0] pc_target,
	input wire logic irq_take,
	output logic [PC_W-1:0] pc_value,
	output logic [PROG_W-1:0] fetch_addr,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [6:0] cpu_off,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	output logic [1:0] bank_sel
);

	localparam int RAM_AW = $clog2(RAM_WORDS);

	generate
		if (PROG_W > PC_W || PROG_W < 1 || RAM_WORDS < RAM_DEPTH || BUS_AW < 10) begin : g_bad_param
			$error("memory_map_bank_decoder: unsupported parameter values");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [PC_W-1:0] pc_r;
	logic [4:0] pc_high_latch_r;
	logic [7:0] status_r;
	logic [7:0] pointer_r;
	apb_state_e apb_r;
	logic pready_r;
	logic [7:0] prdata_r;
	logic cpu_rvalid_r;
	logic [7:0] cpu_rdata_r;
	logic st1_v_r;
	logic st1_apb_r;
	region_e st1_region_r;
	logic [7:0] st1_sfr_r;

	data_req_s launch;
	logic launch_v;
	logic apb_go;
	logic [8:0] dec_addr;
	logic [6:0] dec_off;
	region_e dec_region;
	logic [RAM_AW-1:0] dec_idx;
	logic [7:0] dec_sfr;
	logic sfr_wr;
	logic pc_low_wr;
	logic ram_we;
	logic [7:0] ram_q;
	logic [7:0] rd_byte;

	assign pc_value = pc_r;
	assign fetch_addr = pc_r[PROG_W-1:0]; // RQ2 RQ3
	assign bank_sel = status_r[STATUS_BANK_HI:STATUS_BANK_LO];
	assign prdata = {24'h000000, prdata_r};
	assign pready = pready_r;
	assign pslverr = 1'b0;
	assign cpu_rdata = cpu_rdata_r;
	assign cpu_rvalid = cpu_rvalid_r;

	// ----------------------------------------------------------------
	// Request selection
	// ----------------------------------------------------------------
	// The core never waits; an APB access waits for a cycle in which no core request is present.
	assign apb_go = psel && penable && !cpu_req && (apb_r == apb_idle);
	assign launch_v = cpu_req || apb_go;

	always_comb begin
		launch.we = cpu_we;
		launch.off = cpu_off;
		launch.wdata = cpu_wdata;
		launch.from_apb = 1'b0;
		launch.blank = 1'b0;
		if (!cpu_req) begin
			launch.we = pwrite && pstrb[0];
			launch.off = paddr[8:2];
			launch.wdata = pwdata[7:0];
			launch.from_apb = 1'b1;
			launch.blank = (paddr[BUS_AW-1:9] != '0) || (paddr[1:0] != 2'b00);
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb begin
		dec_addr = {status_r[STATUS_BANK_HI:STATUS_BANK_LO], launch.off}; // RQ10 RQ12
		if (launch.off == OFF_INDIRECT) begin
			dec_addr = {status_r[STATUS_IRP], pointer_r}; // RQ11 RQ13
		end
		dec_off = dec_addr[6:0];
		dec_region = region_none;
		dec_idx = '0;
		dec_sfr = 8'h00;
		// A pointer that aims at the indirect port itself reads as zero.
		if (launch.blank || dec_off == OFF_INDIRECT) begin
			dec_region = region_none;
		end else if (dec_off <= SFR_TOP) begin
			dec_region = region_sfr; // RQ6
			case (dec_off)
				OFF_PC_LOW: dec_sfr = pc_r[7:0];
				OFF_STATUS: dec_sfr = status_r;
				OFF_POINTER: dec_sfr = pointer_r;
				OFF_PC_HIGH_LATCH: dec_sfr = {3'b000, pc_high_latch_r};
				default: dec_sfr = 8'h00; // RQ9
			endcase
		end else if (dec_off >= COMMON_LO) begin
			dec_region = region_ram;
			dec_idx = RAM_AW'(RAM_BANK0_WORDS) + RAM_AW'(dec_off[3:0]); // RQ8
		end else if (dec_addr[8:7] == 2'b00 && dec_off >= RAM_LO && dec_off <= RAM_HI) begin
			dec_region = region_ram;
			dec_idx = RAM_AW'(dec_off - RAM_LO); // RQ7
		end
	end

	assign sfr_wr = launch_v && launch.we && (dec_region == region_sfr);
	assign pc_low_wr = sfr_wr && (dec_off == OFF_PC_LOW);
	assign ram_we = launch_v && launch.we && (dec_region == region_ram);

	data_ram #(
		.DEPTH(RAM_WORDS),
		.AW(RAM_AW)
	) u_ram (
		.clk(pclk),
		.rst_n(presetn),
		.we(ram_we),
		.addr(dec_idx),
		.wdata(launch.wdata),
		.rdata_q(ram_q)
	);

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	// Interrupt entry outranks a branch, which outranks a computed jump.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_r <= RESET_VECTOR; // RQ4
		end else if (irq_take) begin
			pc_r <= IRQ_VECTOR; // RQ5
		end else if (pc_jump) begin
			pc_r <= pc_target;
		end else if (pc_low_wr) begin
			pc_r <= {pc_high_latch_r, launch.wdata};
		end else if (pc_step) begin
			pc_r <= pc_r + 13'h0001; // RQ1
		end
	end

	// ----------------------------------------------------------------
	// Core registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= STATUS_RESET;
		end else if (sfr_wr && dec_off == OFF_STATUS) begin
			// Time-out and power-down flags are read-only here.
			status_r <= (status_r & ~STATUS_WMASK) | (launch.wdata & STATUS_WMASK); // RQ10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pointer_r <= POINTER_RESET;
		end else if (sfr_wr && dec_off == OFF_POINTER) begin
			pointer_r <= launch.wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_high_latch_r <= PC_HIGH_LATCH_RESET;
		end else if (sfr_wr && dec_off == OFF_PC_HIGH_LATCH) begin
			pc_high_latch_r <= launch.wdata[4:0];
		end
	end

	// ----------------------------------------------------------------
	// Read pipeline
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st1_v_r <= 1'b0;
			st1_apb_r <= 1'b0;
			st1_region_r <= region_none;
			st1_sfr_r <= 8'h00;
		end else begin
			st1_v_r <= launch_v;
			st1_apb_r <= launch_v && launch.from_apb;
			st1_region_r <= dec_region;
			st1_sfr_r <= dec_sfr;
		end
	end

	always_comb begin
		unique case (st1_region_r)
			region_ram: rd_byte = ram_q;
			region_sfr: rd_byte = st1_sfr_r;
			region_none: rd_byte = 8'h00; // RQ9
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_rvalid_r <= 1'b0;
			cpu_rdata_r <= 8'h00;
		end else begin
			cpu_rvalid_r <= st1_v_r && !st1_apb_r;
			if (st1_v_r && !st1_apb_r) begin
				cpu_rdata_r <= rd_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_r <= apb_idle;
			pready_r <= 1'b0;
			prdata_r <= 8'h00;
		end else begin
			unique case (apb_r)
				apb_idle: begin
					if (apb_go) begin
						apb_r <= apb_busy;
					end
				end
				apb_busy: begin
					apb_r <= apb_done;
					pready_r <= 1'b1;
					prdata_r <= rd_byte;
				end
				apb_done: begin
					apb_r <= apb_idle;
					pready_r <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic seen_edge_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_edge_r <= 1'b0;
		end else begin
			seen_edge_r <= 1'b1;
		end
	end

	property p_reset_vector;
		@(posedge pclk) disable iff (!presetn) !seen_edge_r |-> pc_r == 13'h0000;
	endproperty
	a_reset_vector: assert property (p_reset_vector) else $error("pc not 0000h after reset"); // RQ4

	property p_irq_vector;
		@(posedge pclk) disable iff (!presetn) irq_take |=> pc_r == 13'h0004;
	endproperty
	a_irq_vector: assert property (p_irq_vector) else $error("interrupt did not load 0004h"); // RQ5

	property p_pc_width;
		@(posedge pclk) disable iff (!presetn)
			pc_step && !irq_take && !pc_jump && !pc_low_wr && pc_r == 13'h1FFF |=> pc_r == 13'h0000;
	endproperty
	a_pc_width: assert property (p_pc_width) else $error("pc not 13 bits wide"); // RQ1

	property p_fetch_wrap;
		@(posedge pclk) disable iff (!presetn)
			pc_step && !irq_take && !pc_jump && !pc_low_wr && pc_r == 13'h03FF
			|=> pc_r == 13'h0400 && fetch_addr == '0;
	endproperty
	a_fetch_wrap: assert property (p_fetch_wrap) else $error("fetch did not wrap"); // RQ3

	property p_unimpl_zero;
		@(posedge pclk) disable iff (!presetn)
			cpu_req && !cpu_we && cpu_off >= 7'h20 && cpu_off <= 7'h3F
			|=> ##1 cpu_rvalid && cpu_rdata == 8'h00;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero"); // RQ9

	property p_sfr_base;
		@(posedge pclk) disable iff (!presetn)
			launch_v && !launch.blank && dec_off <= 7'h1F |-> dec_region != region_ram;
	endproperty
	a_sfr_base: assert property (p_sfr_base) else $error("register offset reached RAM"); // RQ6

	property p_gpr_map;
		@(posedge pclk) disable iff (!presetn)
			launch_v && !launch.blank && dec_addr >= 9'h040 && dec_addr <= 9'h06F
			|-> ram_we == launch.we && dec_idx == RAM_AW'(dec_addr - 9'h040);
	endproperty
	a_gpr_map: assert property (p_gpr_map) else $error("bank 0 RAM mapped wrong"); // RQ7

	property p_common_map;
		@(posedge pclk) disable iff (!presetn)
			launch_v && !launch.blank && dec_off >= 7'h70 |-> dec_region == region_ram && dec_idx[3:0] == dec_off[3:0];
	endproperty
	a_common_map: assert property (p_common_map) else $error("common RAM not shared"); // RQ8

	property p_bank_write;
		@(posedge pclk) disable iff (!presetn)
			sfr_wr && dec_off == OFF_STATUS |=> bank_sel == $past(launch.wdata[6:5]);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank select not updated"); // RQ10

	property p_direct_addr;
		@(posedge pclk) disable iff (!presetn)
			launch_v && launch.off != 7'h00 |-> dec_addr == {bank_sel, launch.off};
	endproperty
	a_direct_addr: assert property (p_direct_addr) else $error("direct address not banked"); // RQ12

	property p_indirect_addr;
		@(posedge pclk) disable iff (!presetn)
			launch_v && launch.off == 7'h00 |-> dec_addr == {status_r[7], pointer_r}
			&& pc_low_wr == (launch.we && !launch.blank && pointer_r[6:0] == OFF_PC_LOW);
	endproperty
	a_indirect_addr: assert property (p_indirect_addr) else $error("indirect not via pointer"); // RQ11 RQ13
endmodule : memory_map_bank_decoder
`default_nettype wire

// [verif/core_model.sv]
// Purpose: Behavioural model of the core that steers the program counter and makes data accesses.
// Assumes: Every signal changes by non-blocking assignment just after a rising edge.
// Notes:   Released data lines carry inverted values so that a stale byte never looks live.

`timescale 1ns/1ns
`default_nettype none

module core_model
	import memory_map_pkg::*;
(
	input wire logic pclk,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_rvalid,
	output logic cpu_req,
	output logic cpu_we,
	output logic [6:0] cpu_off,
	output logic [7:0] cpu_wdata,
	output logic pc_step,
	output logic pc_jump,
	output logic [PC_W-1:0] pc_target,
	output logic irq_take
);
	initial begin
		cpu_req = 1'b0;
		cpu_we = 1'b0;
		cpu_off = 7'h55;
		cpu_wdata = 8'hAA;
		pc_step = 1'b0;
		pc_jump = 1'b0;
		pc_target = 13'h0AAA;
		irq_take = 1'b0;
	end

	// The answer is awaited with a bound, so a lost answer shows as a wrong read.
	task automatic access(input logic we, input logic [6:0] off, input logic [7:0] wdata,
		output logic [7:0] rdata);
		int n;
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_off <= off;
		cpu_wdata <= wdata;
		@(posedge pclk);
		cpu_req <= 1'b0;
		cpu_we <= ~we;
		cpu_off <= ~off;
		cpu_wdata <= ~wdata;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cpu_rvalid !== 1'b1 && n < 8);
		rdata = (n < 8) ? cpu_rdata : 8'hXX;
	endtask : access

	task automatic pc_ctl(input logic step, input logic jump, input logic [PC_W-1:0] target, input logic irq);
		pc_step <= step;
		pc_jump <= jump;
		pc_target <= target;
		irq_take <= irq;
		@(posedge pclk);
		pc_step <= 1'b0;
		pc_jump <= 1'b0;
		pc_target <= ~target;
		irq_take <= 1'b0;
		@(posedge pclk);
	endtask : pc_ctl
endmodule : core_model

`default_nettype wire

// [verif/memory_map_bank_decoder_tb_top.sv]
// Purpose: Self-checking bench for the program counter and the banked data decoder.
// Assumes: Default parameters; APB and core requests never overlap in time.
// Notes:   Expected values are worked out from the memory map, never read from the design.

`timescale 1ns/1ns
`default_nettype none

module memory_map_bank_decoder_tb_top
	import memory_map_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr;
	logic pc_step, pc_jump, irq_take, cpu_req, cpu_we, cpu_rvalid;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, ard;
	logic [3:0] pstrb;
	logic [PC_W-1:0] pc_target, pc_value;
	logic [PROG_AW-1:0] fetch_addr;
	logic [6:0] cpu_off;
	logic [7:0] cpu_wdata, cpu_rdata, crd;
	logic [1:0] bank_sel;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;

	core_model core (.pclk(pclk), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_req(cpu_req),
		.cpu_we(cpu_we), .cpu_off(cpu_off), .cpu_wdata(cpu_wdata), .pc_step(pc_step),
		.pc_jump(pc_jump), .pc_target(pc_target), .irq_take(irq_take));

	memory_map_bank_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pc_step(pc_step), .pc_jump(pc_jump),
		.pc_target(pc_target), .irq_take(irq_take), .pc_value(pc_value), .fetch_addr(fetch_addr),
		.cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_off(cpu_off), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .bank_sel(bank_sel));

	always #10 pclk = ~pclk;

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Completion, check and access tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		ard = prdata;
		chk({31'h0, pslverr}, 32'h0, "apb error");
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~wdata;
		chk(32'(n < 16), 32'h1, "apb answer");
		@(posedge pclk);
	endtask : apb

	task automatic apb_rd(input logic [11:0] addr, input logic [31:0] exp, input string what);
		apb(1'b0, addr, 32'h0);
		chk(ard, exp, what);
	endtask : apb_rd

	task automatic cpu_rd(input logic [6:0] off, input logic [7:0] exp, input string what);
		core.access(1'b0, off, 8'h00, crd);
		chk({24'h0, crd}, {24'h0, exp}, what);
	endtask : cpu_rd

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({19'h0, pc_value}, 32'h0, "reset pc");
		chk({30'h0, bank_sel}, 32'h0, "reset bank");
		apb_rd(12'h00C, 32'h18, "reset status");
		$display("test reset done");

		core.pc_ctl(1'b0, 1'b0, 13'h0000, 1'b1);
		chk({19'h0, pc_value}, 32'h4, "irq vector");
		core.pc_ctl(1'b0, 1'b1, 13'h1FFF, 1'b0);
		chk({22'h0, fetch_addr}, 32'h3FF, "wrap top");
		core.pc_ctl(1'b1, 1'b0, 13'h0000, 1'b0);
		chk({19'h0, pc_value}, 32'h0, "pc roll");
		core.pc_ctl(1'b0, 1'b1, 13'h0ABC, 1'b0);
		chk({19'h0, pc_value}, 32'hABC, "pc wide");
		chk({22'h0, fetch_addr}, 32'h2BC, "fetch wrap");
		core.pc_ctl(1'b0, 1'b1, 13'h03FF, 1'b0);
		core.pc_ctl(1'b1, 1'b0, 13'h0000, 1'b0);
		chk({19'h0, pc_value}, 32'h400, "pc past space");
		chk({22'h0, fetch_addr}, 32'h0, "fetch wrap low");
		core.pc_ctl(1'b1, 1'b1, 13'h1234, 1'b1);
		chk({19'h0, pc_value}, 32'h4, "irq wins");
		apb(1'b1, 12'h028, 32'h03);
		apb(1'b1, 12'h008, 32'h10);
		chk({19'h0, pc_value}, 32'h310, "pc load");
		$display("test program done");

		core.access(1'b1, 7'h40, 8'h5A, crd);
		core.access(1'b1, 7'h6F, 8'h96, crd);
		cpu_rd(7'h6F, 8'h96, "ram top");
		cpu_rd(7'h3F, 8'h00, "gap");
		for (int b = 0; b < 4; b++) begin
			apb(1'b1, 12'h00C, 32'(b * 32));
			chk({30'h0, bank_sel}, 32'(b), "bank select");
			apb_rd(12'h00C, 32'(24 + b * 32), "status");
			apb(1'b1, 12'h004, 32'hFF);
			apb_rd(12'h004, 32'h0, "peripheral");
			if (b != 0) apb(1'b1, 12'h100, 32'hEE);
			apb_rd(12'h100, (b == 0) ? 32'h5A : 32'h0, "bank ram");
			apb(1'b1, 12'(448 + 4 * b), 32'(192 + b));
		end
		for (int b = 0; b < 4; b++) begin
			cpu_rd(7'(112 + b), 8'(192 + b), "common");
		end
		$display("test banks done");

		apb(1'b1, 12'h00C, 32'h00);
		cpu_rd(7'h40, 8'h5A, "ram kept");
		core.access(1'b1, 7'h04, 8'h40, crd);
		cpu_rd(7'h00, 8'h5A, "indirect");
		apb(1'b1, 12'h00C, 32'h80);
		cpu_rd(7'h00, 8'h00, "indirect high bank");
		apb(1'b1, 12'h00C, 32'h00);
		core.access(1'b1, 7'h04, 8'hF0, crd);
		core.access(1'b1, 7'h00, 8'hA5, crd);
		cpu_rd(7'h70, 8'hA5, "indirect common");
		cpu_rd(7'h04, 8'hF0, "pointer");
		core.access(1'b1, 7'h04, 8'h00, crd);
		cpu_rd(7'h00, 8'h00, "self pointer");
		$display("test indirect done");

		apb_rd(12'h200, 32'h0, "unmapped");
		apb(1'b1, 12'h101, 32'h77);
		pstrb <= 4'h0;
		apb(1'b1, 12'h100, 32'h11);
		pstrb <= 4'hF;
		apb_rd(12'h100, 32'h5A, "refused writes");
		$display("test refusals done");

		apb(1'b1, 12'h00C, 32'h60);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({19'h0, pc_value}, 32'h0, "second reset pc");
		chk({30'h0, bank_sel}, 32'h0, "second reset bank");
		cpu_rd(7'h40, 8'h5A, "ram after reset");
		$display("test second reset done");
		complete_run();
	end
endmodule : memory_map_bank_decoder_tb_top

`default_nettype wire
